/* design/flow_ctrl_pkg.sv */
package flow_ctrl_pkg;

  // Program space
  localparam int         PC_W          = 12;
  localparam logic [11:0] PC_RESET     = 12'h000;
  localparam logic [11:0] VEC_EXT      = 12'h003;
  localparam logic [11:0] VEC_TMR      = 12'h007;

  // Data RAM map
  localparam int         RAM_DEPTH     = 128;
  localparam logic [6:0] BANK0_BASE    = 7'h00;
  localparam logic [6:0] BANK1_BASE    = 7'h18;
  localparam logic [6:0] STACK_BASE    = 7'h08;
  localparam logic [2:0] SP_RESET      = 3'h0;

  // Status word field positions
  localparam int PSW_SP_LSB   = 0;
  localparam int PSW_BS_BIT   = 4;
  localparam int PSW_F0_BIT   = 5;
  localparam int PSW_AC_BIT   = 6;
  localparam int PSW_CY_BIT   = 7;
  localparam logic [7:0] PSW_RESET = 8'h08;

  // Timing
  localparam int OSC_DIV       = 480;
  localparam int ALE_DIV       = 15;
  localparam int EVENT_MIN_ALE = 3;

  // Register bus offsets
  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_ACC   = 8'h04;
  localparam logic [7:0] ADDR_PC    = 8'h08;
  localparam logic [7:0] ADDR_PSW   = 8'h0c;
  localparam logic [7:0] ADDR_CNT   = 8'h10;
  localparam logic [7:0] ADDR_STAT  = 8'h14;
  localparam logic [7:0] ADDR_RAM   = 8'h80;
  localparam logic [7:0] ADDR_RADR  = 8'h18;

  typedef enum logic [4:0] {
    CMD_NOP      = 5'h00,
    CMD_SELECT_PROGRAM_BANK_ZERO  = 5'h01,
    CMD_SELECT_PROGRAM_BANK_ONE  = 5'h02,
    CMD_SEL_RB0  = 5'h03,
    CMD_SELECT_REGISTER_BANK_ONE  = 5'h04,
    CMD_JMP      = 5'h05,
    CMD_CALL     = 5'h06,
    CMD_RET      = 5'h07,
    CMD_RETURN_RESTORE_STATUS     = 5'h08,
    CMD_EN_I     = 5'h09,
    CMD_DIS_I    = 5'h0a,
    CMD_EN_TCNTI = 5'h0b,
    CMD_DIS_TCNTI= 5'h0c,
    CMD_RUN_T    = 5'h0d,
    CMD_RUN_CNT  = 5'h0e,
    CMD_HALT     = 5'h0f,
    CMD_LD_CNT   = 5'h10,
    CMD_RD_CNT   = 5'h11,
    CMD_JTF      = 5'h12,
    CMD_SET_F0   = 5'h13,
    CMD_CLR_F0   = 5'h14,
    CMD_SET_F1   = 5'h15,
    CMD_CLR_F1   = 5'h16,
    CMD_LD_PSW   = 5'h17,
    CMD_RD_PSW   = 5'h18,
    CMD_EN_CLK   = 5'h19,
    CMD_WR_REG   = 5'h1a,
    CMD_WR_IND   = 5'h1b,
    CMD_RD_IND   = 5'h1c
  } cmd_e;

  typedef enum logic [2:0] {
    CNT_STOP  = 3'b001,
    CNT_TIMER = 3'b010,
    CNT_EVENT = 3'b100
  } cnt_mode_e;

  typedef struct packed {
    logic [7:0]  processor_status_word;
    logic [PC_W-1:0] pc;
  } frame_s;

endpackage

/* design/flow_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - 4 KB program space in two banks; jump/call loads bank into PC top bit.
// - Reset clears PC, SP, banks; bus floats unless strapped; ports input.
// - Reset disables interrupts, stops counter, clears flags, disables clock.
// - Active-low level interrupt sampled each strobe; calls location 3.
// - Enabled counter overflow interrupt calls location 7.
// - External request wins over simultaneous counter overflow request.
// - Taken interrupt blocks further ones until restoring return.
// - Call saves PC and four status bits in eight entries at RAM 8-23.
// - Pointer starts at RAM 8/9; write entry then increment pointer.
// - Return decrements pointer then reloads PC; restoring form restores status.
// - Timer mode counts at oscillator divided by 480.
// - Event mode counts falling edges; source keeps periods three strobes long.
// - Counter loads and reads via accumulator; reset leaves it unchanged.
// - Counter stops on reset or halt until timer or event start.
// - Running counter wraps FF to zero and keeps counting.
// - Each wrap sets overflow flag and raises timer request.
// - Jump-on-timer-flag tests and clears the flag; reset clears it.
// - Two user flags set, cleared, read back; first lives in status word.
// - Status word moves to and from accumulator.
// - Working registers at RAM 0-7, or 24-31 after bank-one select.
// - All 128 RAM locations reachable through pointer registers 0 and 1.
// - Address-latch strobe pulses exactly once per machine cycle.
module flow_ctrl
  import flow_ctrl_pkg::*;
#(
  parameter int OSC_DIVIDE = OSC_DIV,
  parameter int ALE_DIVIDE = ALE_DIV
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Pins
  input  wire logic        INT_N,
  input  wire logic        EVENT_COUNT_IN,
  input  wire logic        EXTERNAL_ACCESS_STRAP,
  output logic             ALE,
  output logic             BUS_OE,
  output logic             PORT_INPUT_MODE,
  output logic             TEST_ZERO_CLOCK_OUT,
  output logic [PC_W-1:0]  PC_OUT
);

  // Machine state
  logic [PC_W-1:0] pc_ff;
  logic [7:0]      psw_ff;
  logic [7:0]      acc_ff;
  logic [7:0]      cnt_ff;
  cnt_mode_e       mode_ff;
  logic            mb_ff, ovf_ff, f1_ff, tirq_ff;
  logic            ext_en_ff, tmr_en_ff, in_isr_ff, clk_en_ff;
  logic [7:0]      ram [RAM_DEPTH];
  logic [6:0]      radr_ff;
  logic [7:0]      tdiv_ff;
  logic [3:0]      adiv_ff;
  logic [8:0]      pdiv_ff;
  logic            ale_ff, ev_d_ff, tclk_ff, stbv_ff, jtf_ff;
  logic [7:0]      stbc_ff;

  // Bus slave state
  logic            aw_ff, w_ff;
  logic [7:0]      awa_ff;
  logic [31:0]     wd_ff;
  logic            wr_go;
  logic            wr_hit;

  assign wr_go = aw_ff && w_ff && !S_AXI_BVALID;

  // Decoded write command for this cycle
  cmd_e       cmd;
  logic       cmd_v;
  logic [7:0] cmd_arg;
  logic [11:0] cmd_tgt;
  always_comb begin
    cmd     = CMD_NOP;
    cmd_v   = 1'b0;
    cmd_arg = wd_ff[15:8];
    cmd_tgt = wd_ff[27:16];
    wr_hit  = 1'b1;
    if (awa_ff == ADDR_CMD) begin
      cmd_v = wr_go;
      cmd   = cmd_e'(wd_ff[4:0]);
    end else if (awa_ff == ADDR_ACC || awa_ff == ADDR_RADR) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Machine cycle strobe: one pulse per ALE_DIVIDE clocks
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      adiv_ff <= 4'h0;
      ale_ff  <= 1'b0;
    end else begin
      ale_ff  <= (adiv_ff == 4'(ALE_DIVIDE - 1));
      adiv_ff <= (adiv_ff == 4'(ALE_DIVIDE - 1)) ? 4'h0 : adiv_ff + 4'h1;
    end
  end

  // Timer prescaler
  logic tick;
  assign tick = (pdiv_ff == 9'(OSC_DIVIDE - 1));
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) pdiv_ff <= 9'h0;
    else pdiv_ff <= tick ? 9'h0 : pdiv_ff + 9'h1;
  end

  // Event input edge, qualified on the strobe so glitches between
  // machine cycles are not counted
  logic ev_fall;
  assign ev_fall = ale_ff && ev_d_ff && !EVENT_COUNT_IN;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) ev_d_ff <= 1'b1;
    else if (ale_ff) ev_d_ff <= EVENT_COUNT_IN;
  end

  // Counter advance
  logic inc, wrap;
  assign inc  = (mode_ff == CNT_TIMER && tick) ||
                (mode_ff == CNT_EVENT && ev_fall);
  assign wrap = inc && cnt_ff == 8'hff;

  // Counter contents: no reset, only loaded by instruction
  always_ff @(posedge CLK) begin
    if (cmd_v && cmd == CMD_LD_CNT) cnt_ff <= acc_ff;
    else if (inc) cnt_ff <= cnt_ff + 8'h01;
  end

  // Counter mode
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) mode_ff <= CNT_STOP;
    else if (cmd_v) begin
      case (cmd)
        CMD_HALT:    mode_ff <= CNT_STOP;
        CMD_RUN_T:   mode_ff <= CNT_TIMER;
        CMD_RUN_CNT: mode_ff <= CNT_EVENT;
        default:     mode_ff <= mode_ff;
      endcase
    end
  end

  // Interrupt arbitration on the strobe
  logic take_ext, take_tmr, take_any;
  assign take_ext = ale_ff && !in_isr_ff && ext_en_ff && !INT_N;
  assign take_tmr = ale_ff && !in_isr_ff && tmr_en_ff && tirq_ff &&
                    !take_ext;
  assign take_any = take_ext || take_tmr;

  // Overflow flag and pending request; set wins over clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_ff  <= 1'b0;
      tirq_ff <= 1'b0;
    end else begin
      if (wrap) ovf_ff <= 1'b1;
      else if (cmd_v && cmd == CMD_JTF) ovf_ff <= 1'b0;
      if (wrap) tirq_ff <= 1'b1;
      else if (take_tmr || !tmr_en_ff) tirq_ff <= 1'b0;
    end
  end

  // Stack frame addresses
  logic [2:0] sp, sp_dec;
  logic [6:0] push_a, pop_a;
  assign sp     = psw_ff[PSW_SP_LSB +: 3];
  assign sp_dec = sp - 3'h1;
  assign push_a = STACK_BASE + {3'h0, sp, 1'b0};
  assign pop_a  = STACK_BASE + {3'h0, sp_dec, 1'b0};

  // Working register address
  logic [6:0] rb_base;
  assign rb_base = psw_ff[PSW_BS_BIT] ? BANK1_BASE : BANK0_BASE;

  logic do_call, do_ret;
  assign do_call = take_any || (cmd_v && cmd == CMD_CALL);
  assign do_ret  = !take_any && cmd_v && (cmd == CMD_RET || cmd == CMD_RETURN_RESTORE_STATUS);

  // Pointer register indirect address
  logic [6:0] ind_a;
  assign ind_a = ram[rb_base + {6'h0, cmd_arg[0]}][6:0];

  // Data RAM: stack pushes and register writes
  always_ff @(posedge CLK) begin
    if (do_call) begin
      ram[push_a]        <= pc_ff[7:0];
      ram[push_a + 7'h1] <= {psw_ff[7:5], psw_ff[PSW_BS_BIT], pc_ff[11:8]};
    end else if (cmd_v && cmd == CMD_WR_REG) begin
      ram[rb_base + {4'h0, cmd_arg[2:0]}] <= acc_ff;
    end else if (cmd_v && cmd == CMD_WR_IND) begin
      ram[ind_a] <= acc_ff;
    end else if (wr_go && awa_ff >= ADDR_RAM) begin
      ram[radr_ff] <= wd_ff[7:0];
    end
  end

  // Program counter and program bank
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pc_ff <= PC_RESET;
      mb_ff <= 1'b0;
    end else if (take_ext) begin
      pc_ff <= VEC_EXT;
    end else if (take_tmr) begin
      pc_ff <= VEC_TMR;
    end else if (do_ret) begin
      pc_ff <= {ram[pop_a + 7'h1][3:0], ram[pop_a]};
    end else if (cmd_v) begin
      case (cmd)
        CMD_SELECT_PROGRAM_BANK_ZERO: mb_ff <= 1'b0;
        CMD_SELECT_PROGRAM_BANK_ONE: mb_ff <= 1'b1;
        CMD_JMP, CMD_CALL: pc_ff <= {mb_ff, cmd_tgt[10:0]};
        default: pc_ff <= pc_ff;
      endcase
    end
  end

  // Status word: stack pointer, bank select, user flag zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      psw_ff <= PSW_RESET;
    end else if (do_call) begin
      psw_ff[PSW_SP_LSB +: 3] <= sp + 3'h1;
    end else if (do_ret) begin
      psw_ff[PSW_SP_LSB +: 3] <= sp_dec;
      if (cmd == CMD_RETURN_RESTORE_STATUS) begin
        psw_ff[7:5]        <= ram[pop_a + 7'h1][7:5];
        psw_ff[PSW_BS_BIT] <= ram[pop_a + 7'h1][4];
      end
    end else if (cmd_v) begin
      case (cmd)
        CMD_SEL_RB0: psw_ff[PSW_BS_BIT] <= 1'b0;
        CMD_SELECT_REGISTER_BANK_ONE: psw_ff[PSW_BS_BIT] <= 1'b1;
        CMD_SET_F0:  psw_ff[PSW_F0_BIT] <= 1'b1;
        CMD_CLR_F0:  psw_ff[PSW_F0_BIT] <= 1'b0;
        CMD_LD_PSW:  psw_ff <= acc_ff | 8'h08;
        default:     psw_ff <= psw_ff;
      endcase
    end
  end

  // Interrupt enables and in-service lockout
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_en_ff <= 1'b0;
      tmr_en_ff <= 1'b0;
      in_isr_ff <= 1'b0;
      f1_ff     <= 1'b0;
      clk_en_ff <= 1'b0;
    end else begin
      if (take_any) in_isr_ff <= 1'b1;
      else if (do_ret && cmd == CMD_RETURN_RESTORE_STATUS) in_isr_ff <= 1'b0;
      if (cmd_v) begin
        case (cmd)
          CMD_EN_I:      ext_en_ff <= 1'b1;
          CMD_DIS_I:     ext_en_ff <= 1'b0;
          CMD_EN_TCNTI:  tmr_en_ff <= 1'b1;
          CMD_DIS_TCNTI: tmr_en_ff <= 1'b0;
          CMD_SET_F1:    f1_ff     <= 1'b1;
          CMD_CLR_F1:    f1_ff     <= 1'b0;
          CMD_EN_CLK:    clk_en_ff <= 1'b1;
          default:       f1_ff     <= f1_ff;
        endcase
      end
    end
  end

  // Accumulator and indirect address register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_ff  <= 8'h00;
      radr_ff <= 7'h00;
      jtf_ff  <= 1'b0;
    end else begin
      if (wr_go && awa_ff == ADDR_ACC) acc_ff <= wd_ff[7:0];
      if (wr_go && awa_ff == ADDR_RADR) radr_ff <= wd_ff[6:0];
      if (cmd_v) begin
        case (cmd)
          CMD_RD_CNT: acc_ff <= cnt_ff;
          CMD_RD_PSW: acc_ff <= psw_ff;
          CMD_RD_IND: acc_ff <= ram[ind_a];
          CMD_JTF:    jtf_ff <= ovf_ff;
          default:    acc_ff <= acc_ff;
        endcase
      end
    end
  end

  // Test-zero clock output: divided clock, only once enabled
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) tclk_ff <= 1'b0;
    else tclk_ff <= clk_en_ff && (adiv_ff < 4'(ALE_DIVIDE / 2));
  end

  // AXI4-Lite write channel
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      awa_ff       <= 8'h00;
      wd_ff        <= 32'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'b00;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_ff  <= 1'b1;
        awa_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_ff  <= 1'b1;
        wd_ff <= S_AXI_WDATA;
      end
      if (wr_go) begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_hit || awa_ff >= ADDR_RAM) ? 2'b00 : 2'b10;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  assign S_AXI_AWREADY = !aw_ff;
  assign S_AXI_WREADY  = !w_ff;

  // AXI4-Lite read channel
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR == ADDR_ACC) rd_val = {24'h0, acc_ff};
    else if (S_AXI_ARADDR == ADDR_PC) rd_val = {20'h0, pc_ff};
    else if (S_AXI_ARADDR == ADDR_PSW) rd_val = {24'h0, psw_ff};
    else if (S_AXI_ARADDR == ADDR_CNT) rd_val = {24'h0, cnt_ff};
    else if (S_AXI_ARADDR == ADDR_STAT)
      rd_val = {24'h0, mode_ff, jtf_ff, in_isr_ff, mb_ff, f1_ff,
                ovf_ff};
    else if (S_AXI_ARADDR == ADDR_RADR) rd_val = {25'h0, radr_ff};
    else if (S_AXI_ARADDR >= ADDR_RAM) rd_val = {24'h0, ram[radr_ff]};
    else if (S_AXI_ARADDR == ADDR_CMD) rd_val = 32'h0;
    else rd_hit = 1'b0;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= 2'b00;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_val;
      S_AXI_RRESP  <= rd_hit ? 2'b00 : 2'b10;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // Pin outputs, all registered
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALE             <= 1'b0;
      BUS_OE          <= 1'b0;
      PORT_INPUT_MODE <= 1'b1;
      PC_OUT          <= PC_RESET;
    end else begin
      ALE             <= ale_ff;
      BUS_OE          <= EXTERNAL_ACCESS_STRAP;
      PORT_INPUT_MODE <= 1'b1;
      PC_OUT          <= pc_ff;
    end
  end
  assign TEST_ZERO_CLOCK_OUT = tclk_ff;

endmodule // flow_ctrl

/* testbench/flow_ctrl_checker.sv */
`timescale 1ns/1ps
module flow_ctrl_checker
  import flow_ctrl_pkg::*;
#(parameter int ALE_DIVIDE = ALE_DIV) (
  // Clock and reset
  input wire logic            CLK,
  input wire logic            RST_N,
  // Register bus
  input wire logic [7:0]      S_AXI_ARADDR,
  input wire logic            S_AXI_ARVALID,
  input wire logic            S_AXI_ARREADY,
  input wire logic [31:0]     S_AXI_RDATA,
  input wire logic [1:0]      S_AXI_RRESP,
  input wire logic            S_AXI_RVALID,
  input wire logic            S_AXI_RREADY,
  input wire logic            S_AXI_AWVALID,
  input wire logic            S_AXI_AWREADY,
  input wire logic            S_AXI_WVALID,
  input wire logic            S_AXI_WREADY,
  input wire logic            S_AXI_BVALID,
  input wire logic            S_AXI_BREADY,
  // Pins
  input wire logic            INT_N,
  input wire logic            EXTERNAL_ACCESS_STRAP,
  input wire logic            ALE,
  input wire logic            BUS_OE,
  input wire logic            PORT_INPUT_MODE,
  input wire logic [PC_W-1:0] PC_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  int   gap_ff;
  logic seen_ff;
  // First strobe after reset has no predecessor to measure from
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap_ff  <= 0;
      seen_ff <= 1'b0;
    end else begin
      gap_ff  <= ALE ? 0 : gap_ff + 1;
      seen_ff <= seen_ff | ALE;
    end
  end
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence rd_hole;
    rd_taken ##0 (S_AXI_ARADDR inside {[8'h1c:8'h7f]});
  endsequence
  a_ale_single: assert property (ALE |=> !ALE)
    else $error("strobe longer than one cycle");
  a_ale_spacing: assert property (ALE && seen_ff |-> gap_ff == ALE_DIVIDE - 1)
    else $error("strobe spacing wrong");
  a_port_input: assert property (PORT_INPUT_MODE)
    else $error("ports left input mode");
  a_bus_float: assert property ($past(RST_N) |-> BUS_OE == $past(EXTERNAL_ACCESS_STRAP))
    else $error("bus drive does not follow strap");
  // Both halves land first, the response is raised one edge later
  a_write_answer: assert property (wr_taken |=> ##1 S_AXI_BVALID)
    else $error("write response missing");
  a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  a_read_answer: assert property (rd_taken |=> S_AXI_RVALID)
    else $error("read data missing");
  a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_read_refused: assert property (rd_hole |=> S_AXI_RRESP == 2'b10)
    else $error("hole not refused");
  a_ext_cause: assert property ($changed(PC_OUT) && PC_OUT == VEC_EXT
    |-> !($past(INT_N) && $past(INT_N, 2)))
    else $error("external vector without request");
endmodule // flow_ctrl_checker

/* testbench/irq_event_model.sv */
`timescale 1ns/1ps
module irq_event_model (
  // Clock, reset, strobe
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ALE,
  // Bench requests
  input wire logic pull_int,
  input wire logic fire,
  // Device pins
  output logic     INT_N,
  output logic     EVENT_COUNT_IN,
  output logic     busy
);
  logic [2:0] ales_ff;
  // Wired-OR request line, pulled high when released
  assign INT_N = !pull_int;
  // Low then high, three strobes each
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      EVENT_COUNT_IN <= 1'b1;
      busy           <= 1'b0;
      ales_ff        <= 3'h0;
    end else if (!busy) begin
      EVENT_COUNT_IN <= !fire;
      busy           <= fire;
      ales_ff        <= 3'h0;
    end else if (ALE) begin
      ales_ff        <= ales_ff + 3'h1;
      EVENT_COUNT_IN <= ales_ff >= 3'h2;
      busy           <= ales_ff != 3'h5;
    end
  end
endmodule // irq_event_model

/* testbench/flow_ctrl_bench.sv */
`timescale 1ns/1ps
module flow_ctrl_bench;
  import flow_ctrl_pkg::*;
  logic        clk = 0, rst_n = 0, strap = 0, pull_int = 0, fire = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rnd = 32'h4bbe6232, rdata;
  logic        awready, wready, bvalid, arready, rvalid, ale, bus_oe;
  logic        port_in, t0_clk, int_n, ev_in, ev_busy;
  logic [1:0]  bresp, rresp;
  logic [11:0] pc_out;
  int          fail_count = 0, checks_done = 0;
  always #4 clk = ~clk;
  flow_ctrl #(.OSC_DIVIDE(16), .ALE_DIVIDE(5)) dut_u (
    .CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .INT_N(int_n), .EVENT_COUNT_IN(ev_in),
    .EXTERNAL_ACCESS_STRAP(strap), .ALE(ale), .BUS_OE(bus_oe),
    .PORT_INPUT_MODE(port_in), .TEST_ZERO_CLOCK_OUT(t0_clk), .PC_OUT(pc_out));
  irq_event_model model_u (.CLK(clk), .RST_N(rst_n), .ALE(ale),
    .pull_int(pull_int), .fire(fire), .INT_N(int_n),
    .EVENT_COUNT_IN(ev_in), .busy(ev_busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
    checks_done++;
    if (v !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic overtime(input int n);
    if (n >= 200) begin
      fail_count++;
      $display("wrong value wait expected done seen timeout");
      tally_and_finish();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    @(posedge clk);
    overtime(n);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
    overtime(n);
  endtask
  task automatic rc(input string s, input logic [7:0] a,
                    input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(s, d & m, e);
  endtask
  task automatic cmd(input cmd_e c, input logic [11:0] t = 12'h0,
                     input logic [7:0] x = 8'h0);
    axw(ADDR_CMD, {4'h0, t, x, 3'h0, c});
  endtask
  task automatic wait_pc(input logic [11:0] v);
    int n;
    n = 0;
    while (pc_out !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    overtime(n);
    chk("pc", {20'h0, pc_out}, {20'h0, v});
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  initial begin
    int          sp;
    logic [31:0] d;
    logic [1:0]  r;
    sp = 0;
    do_reset();
    chk("pc", {20'h0, pc_out}, 32'h0);
    chk("ports", {31'h0, port_in}, 32'h1);
    chk("clkout", {31'h0, t0_clk}, 32'h0);
    rc("psw", ADDR_PSW, 32'h08, 32'hff);
    rc("stat", ADDR_STAT, 32'h20, 32'hef);
    axr(8'h40, d, r);
    chk("resp", {30'h0, r}, 32'h2);
    $display("done: reset and hole");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      strap <= rnd[16];
      axw(ADDR_ACC, {24'h0, rnd[7:0]});
      cmd(CMD_LD_CNT);
      rc("cnt", ADDR_CNT, {24'h0, rnd[7:0]}, 32'hff);
      axw(ADDR_ACC, 32'h0);
      cmd(CMD_RD_CNT);
      rc("acc", ADDR_ACC, {24'h0, rnd[7:0]}, 32'hff);
      axw(ADDR_ACC, {24'h0, rnd[15:8]});
      cmd(CMD_LD_PSW);
      rc("psw", ADDR_PSW, {24'h0, rnd[15:8] | 8'h08}, 32'hff);
      cmd(CMD_RD_PSW);
      rc("acc", ADDR_ACC, {24'h0, rnd[15:8] | 8'h08}, 32'hff);
    end
    axw(ADDR_ACC, 32'h0);
    cmd(CMD_LD_PSW);
    $display("done: counter and status moves");
    cmd(CMD_SELECT_PROGRAM_BANK_ONE);
    cmd(CMD_JMP, 12'h123);
    chk("pc", {20'h0, pc_out}, 32'h923);
    cmd(CMD_SELECT_PROGRAM_BANK_ZERO);
    cmd(CMD_JMP, 12'h923);
    chk("pc", {20'h0, pc_out}, 32'h123);
    for (int i = 0; i < 9; i++) begin
      cmd(CMD_CALL, 12'h100 + 12'(i));
      sp = (sp + 1) % 8;
      chk("pc", {20'h0, pc_out}, 32'h100 + i);
      rc("sp", ADDR_PSW, sp, 32'h07);
    end
    for (int i = 0; i < 9; i++) begin
      cmd(CMD_RET);
      sp = (sp + 7) % 8;
      rc("sp", ADDR_PSW, sp, 32'h07);
    end
    $display("done: banks and stack");
    cmd(CMD_SELECT_REGISTER_BANK_ONE);
    rc("psw", ADDR_PSW, 32'h18, 32'h38);
    axw(ADDR_ACC, 32'h7f);
    cmd(CMD_WR_REG);
    axw(ADDR_RADR, 32'h18);
    rc("r0", ADDR_RAM, 32'h7f, 32'hff);
    axw(ADDR_ACC, 32'ha5);
    cmd(CMD_WR_IND);
    axw(ADDR_RADR, 32'h7f);
    rc("ind", ADDR_RAM, 32'ha5, 32'hff);
    cmd(CMD_SEL_RB0);
    cmd(CMD_SET_F0);
    cmd(CMD_SET_F1);
    rc("f0", ADDR_PSW, 32'h28, 32'h38);
    rc("f1", ADDR_STAT, 32'h02, 32'h02);
    cmd(CMD_CLR_F0);
    cmd(CMD_CLR_F1);
    rc("f0", ADDR_PSW, 32'h0, 32'h20);
    rc("f1", ADDR_STAT, 32'h0, 32'h02);
    $display("done: registers and flags");
    cmd(CMD_JMP, 12'h234);
    axw(ADDR_ACC, 32'h0);
    cmd(CMD_LD_CNT);
    cmd(CMD_RUN_T);
    repeat (160) @(posedge clk);
    cmd(CMD_HALT);
    axr(ADDR_CNT, d, r);
    chk("rate", {31'h0, d[7:0] inside {[8'd9:8'd11]}}, 32'h1);
    repeat (40) @(posedge clk);
    rc("halt", ADDR_CNT, d, 32'hff);
    axw(ADDR_ACC, 32'hff);
    cmd(CMD_LD_CNT);
    cmd(CMD_RUN_T);
    repeat (40) @(posedge clk);
    cmd(CMD_HALT);
    axr(ADDR_CNT, d, r);
    chk("wrap", {31'h0, d[7:0] < 8'h4}, 32'h1);
    rc("ovf", ADDR_STAT, 32'h1, 32'h1);
    chk("pc", {20'h0, pc_out}, 32'h234);
    cmd(CMD_JTF);
    rc("jtf", ADDR_STAT, 32'h10, 32'h11);
    cmd(CMD_JTF);
    rc("jtf", ADDR_STAT, 32'h0, 32'h11);
    $display("done: timer");
    cmd(CMD_JMP, 12'h050);
    axw(ADDR_ACC, 32'hff);
    cmd(CMD_LD_CNT);
    cmd(CMD_RUN_CNT);
    cmd(CMD_EN_I);
    cmd(CMD_EN_TCNTI);
    pull_int <= 1'b1;
    wait_pc(VEC_EXT);
    rc("sp", ADDR_PSW, 32'h1, 32'h7);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    for (int n = 0; ev_busy && n < 100; n++) @(posedge clk);
    chk("evbusy", {31'h0, ev_busy}, 32'h0);
    rc("ovf", ADDR_STAT, 32'h9, 32'h9);
    chk("pc", {20'h0, pc_out}, 32'h3);
    cmd(CMD_RETURN_RESTORE_STATUS);
    repeat (30) @(posedge clk);
    chk("pc", {20'h0, pc_out}, 32'h3);
    pull_int <= 1'b0;
    cmd(CMD_RETURN_RESTORE_STATUS);
    wait_pc(VEC_TMR);
    cmd(CMD_RET);
    rc("isr", ADDR_STAT, 32'h8, 32'h8);
    pull_int <= 1'b1;
    repeat (30) @(posedge clk);
    chk("ign", {31'h0, pc_out == VEC_EXT}, 32'h0);
    pull_int <= 1'b0;
    cmd(CMD_RETURN_RESTORE_STATUS);
    rc("isr", ADDR_STAT, 32'h0, 32'h8);
    $display("done: interrupts");
    axw(ADDR_ACC, 32'h3c);
    cmd(CMD_LD_CNT);
    cmd(CMD_SET_F0);
    cmd(CMD_SET_F1);
    cmd(CMD_SELECT_PROGRAM_BANK_ONE);
    cmd(CMD_EN_CLK);
    cmd(CMD_EN_I);
    do_reset();
    rc("cnt", ADDR_CNT, 32'h3c, 32'hff);
    rc("psw", ADDR_PSW, 32'h08, 32'hff);
    rc("stat", ADDR_STAT, 32'h20, 32'hef);
    chk("clkout", {31'h0, t0_clk}, 32'h0);
    pull_int <= 1'b1;
    repeat (30) @(posedge clk);
    chk("pc", {20'h0, pc_out}, 32'h0);
    $display("done: second reset");
    tally_and_finish();
  end
endmodule // flow_ctrl_bench
bind flow_ctrl flow_ctrl_checker #(.ALE_DIVIDE(ALE_DIVIDE)) chk_u (
  .CLK(CLK), .RST_N(RST_N), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .INT_N(INT_N),
  .EXTERNAL_ACCESS_STRAP(EXTERNAL_ACCESS_STRAP), .ALE(ALE), .BUS_OE(BUS_OE),
  .PORT_INPUT_MODE(PORT_INPUT_MODE), .PC_OUT(PC_OUT));
